/* File: pobc_consts.vh */
// constants for the pll and output bank configuration decoder
// assumes a 96-bit configuration word delivered as twelve bytes, first byte = bits 95:88
//
// Summary of operation
// - pll on only if bit57 and pin low
// - bit58 set syncs to rising reference edge
// - bits 51:48 give multiplier, 0011 gives four
// - bit60 one selects 100-250 MHz vco range
// - bit59 and pin low make disabled outputs tri-state
// - bank1 on only if bit56 and pin low
// - bank2 off if bit55 or pin high
// - bank3 on only if bit54 and pin low
// - bank4 on only if bit53 and pin low
// - bank5 off if bit52 or pin high
// - feedback bank is always enabled
// - five-bit skew fields 29:25 down to 4:0
// - two-bit io standard fields 47:46 down to 37:36
// - commit after stop with twelve bytes, or on a ctrl commit write of the staged word
// - all bits read zero until restore completes
`ifndef POBC_CONSTS_VH
`define POBC_CONSTS_VH

`define POBC_CFG_W 96
`define POBC_CFG_BYTES 12
`define POBC_BIT_VCO_HIGH 60
`define POBC_BIT_DIS_STATE 59
`define POBC_BIT_REF_EDGE 58
`define POBC_BIT_PLL_OFF 57
`define POBC_BIT_BANK1_OFF 56
`define POBC_BIT_BANK2_OFF 55
`define POBC_BIT_BANK3_OFF 54
`define POBC_BIT_BANK4_OFF 53
`define POBC_BIT_BANK5_OFF 52
`define POBC_FBM_MSB 51
`define POBC_FBM_LSB 48
`define POBC_IOSTD_LSB 36
`define POBC_SKEW_LSB 0
`define POBC_RSVD_MSB 95
`define POBC_RSVD_LSB 62

`define POBC_ADDR_CFG0 8'h00
`define POBC_ADDR_CFG1 8'h04
`define POBC_ADDR_CFG2 8'h08
`define POBC_ADDR_STAGE0 8'h0C
`define POBC_ADDR_STAGE1 8'h10
`define POBC_ADDR_STAGE2 8'h14
`define POBC_ADDR_CTRL 8'h18
`define POBC_ADDR_STATUS 8'h1C

`define POBC_CTRL_COMMIT 0
`define POBC_ST_RESTORED 0
`define POBC_ST_ABORT_ERR 1
`define POBC_ST_PLL_EN 2
`define POBC_ST_HIZ 3
`define POBC_ST_BANK_LSB 8
`define POBC_ST_CNT_LSB 16

`endif

/* File: pobc_skew_decode.v */
// decoder for one five-bit skew or frequency selection field
// assumes the parent registers the results
`timescale 1ns/1ps
module pobc_skew_decode (
    input wire [4:0] i_code,
    output reg [3:0] o_skew_steps,
    output reg o_invert,
    output reg o_div2,
    output reg o_div4,
    output reg o_code_valid
);
    always @* begin
        o_skew_steps = 4'h0;
        o_invert = 1'b0;
        o_div2 = 1'b0;
        o_div4 = 1'b0;
        o_code_valid = 1'b1;
        // 00001..00111 -> +7..+1, 01001..01111 -> -1..-7, both equal 8 - code
        if (i_code == 5'h00) begin
            o_skew_steps = 4'h0;
        end else if (i_code[4:3] == 2'b00 || (i_code[4:3] == 2'b01 && i_code[2:0] != 3'h0)) begin
            o_skew_steps = 4'h8 - i_code[3:0];
        end else if (i_code == 5'h10) begin
            o_invert = 1'b1;
        end else if (i_code == 5'h11) begin
            o_div2 = 1'b1;
        end else if (i_code == 5'h12) begin
            o_div4 = 1'b1;
        end else begin
            o_code_valid = 1'b0;
        end
    end
endmodule // pobc_skew_decode

/* File: pobc_frame_rx.v */
// gathers configuration bytes of one programming frame into a word
// assumes framing strobes come from the serial programming interface, synchronous to i_clk
`timescale 1ns/1ps
`include "pobc_consts.vh"
module pobc_frame_rx #(
    parameter NBYTES = `POBC_CFG_BYTES
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_frame_start,
    input wire i_frame_stop,
    input wire i_frame_abort,
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    output reg [NBYTES*8-1:0] o_word,
    output reg o_commit,
    output reg o_abort,
    output reg [4:0] o_count
);
    reg active;
    reg bad;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word <= {(NBYTES*8){1'b0}};
            o_commit <= 1'b0;
            o_abort <= 1'b0;
            o_count <= 5'h00;
            active <= 1'b0;
            bad <= 1'b0;
        end else begin
            o_commit <= 1'b0;
            o_abort <= 1'b0;
            if (i_frame_start) begin
                active <= 1'b1;
                bad <= 1'b0;
                o_count <= 5'h00;
            end else if (active && i_frame_abort) begin
                active <= 1'b0;
                o_abort <= 1'b1;
            end else if (active && i_frame_stop) begin
                active <= 1'b0;
                // short, long or broken frames leave the live word alone
                if (!bad && o_count == NBYTES[4:0]) begin
                    o_commit <= 1'b1;
                end else begin
                    o_abort <= 1'b1;
                end
            end else if (active && i_byte_valid) begin
                o_word <= {o_word[NBYTES*8-9:0], i_byte};
                if (o_count == NBYTES[4:0]) begin
                    bad <= 1'b1;
                end else begin
                    o_count <= o_count + 5'h01;
                end
            end
        end
    end
endmodule // pobc_frame_rx

/* File: pobc_decode.v */
// pll and output bank configuration decoder with register port
// assumes synchronous pins, a frame byte source and a one-cycle strobe register master
`timescale 1ns/1ps
`include "pobc_consts.vh"
module pobc_decode #(
    parameter NBANK = 6
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_frame_start,
    input wire i_frame_stop,
    input wire i_frame_abort,
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    input wire i_restore_done,
    input wire i_pll_disable_pin,
    input wire i_disabled_output_state_pin,
    input wire i_bank1_output_disable_pin,
    input wire i_bank2_output_disable_pin,
    input wire i_bank3_output_disable_pin,
    input wire i_bank4_output_disable_pin,
    input wire i_bank5_output_disable_pin,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output reg o_pll_enable,
    output reg o_pll_bypass,
    output reg o_ref_rising_edge,
    output reg [3:0] o_fb_mult_code,
    output reg [3:0] o_fb_mult_factor,
    output reg o_vco_high_range,
    output reg o_disabled_hiz,
    output reg [NBANK-1:0] o_bank_enable,
    output reg [NBANK*5-1:0] o_skew_sel,
    output reg [NBANK*2-1:0] o_io_std,
    output reg [NBANK*4-1:0] o_skew_steps,
    output reg [NBANK-1:0] o_invert,
    output reg [NBANK-1:0] o_div2,
    output reg [NBANK-1:0] o_div4,
    output reg [NBANK-1:0] o_skew_code_valid
);
    localparam CW = `POBC_CFG_W;

    reg [CW-1:0] cfg;
    reg [CW-1:0] stage;
    reg restored;
    reg abort_err;

    wire [CW-1:0] rx_word;
    wire rx_commit;
    wire rx_abort;
    wire [4:0] rx_count;

    wire [CW-1:0] live;
    wire next_pll_enable;
    wire next_hiz;
    wire [NBANK-1:0] next_bank_enable;
    wire [3:0] fbm;
    reg [3:0] next_factor;

    wire [NBANK*4-1:0] dec_steps;
    wire [NBANK-1:0] dec_inv;
    wire [NBANK-1:0] dec_div2;
    wire [NBANK-1:0] dec_div4;
    wire [NBANK-1:0] dec_valid;

    wire wr_cmd;
    wire [31:0] status;
    reg [31:0] next_rdata;

    pobc_frame_rx #(
        .NBYTES(`POBC_CFG_BYTES)
    ) u_rx (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_frame_start(i_frame_start),
        .i_frame_stop(i_frame_stop),
        .i_frame_abort(i_frame_abort),
        .i_byte_valid(i_byte_valid),
        .i_byte(i_byte),
        .o_word(rx_word),
        .o_commit(rx_commit),
        .o_abort(rx_abort),
        .o_count(rx_count)
    );

    // live word is all zero until power-up restore is done
    assign live = restored ? cfg : {CW{1'b0}};

    assign wr_cmd = i_wr && i_addr == `POBC_ADDR_CTRL && i_wdata[`POBC_CTRL_COMMIT];

    // configuration store: frame commit has priority over a software commit
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg <= {CW{1'b0}};
        end else if (rx_commit) begin
            cfg <= rx_word;
        end else if (wr_cmd) begin
            cfg <= stage;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            restored <= 1'b0;
        end else if (i_restore_done) begin
            restored <= 1'b1;
        end
    end

    // staging word for the register-port load path
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage <= {CW{1'b0}};
        end else if (i_wr) begin
            case (i_addr)
                `POBC_ADDR_STAGE0: begin
                    stage[31:0] <= i_wdata;
                end
                `POBC_ADDR_STAGE1: begin
                    stage[63:32] <= i_wdata;
                end
                `POBC_ADDR_STAGE2: begin
                    stage[95:64] <= i_wdata;
                end
                default: begin
                    stage <= stage;
                end
            endcase
        end
    end

    // sticky broken-frame flag, write one to clear, a new event wins
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            abort_err <= 1'b0;
        end else if (rx_abort) begin
            abort_err <= 1'b1;
        end else if (i_wr && i_addr == `POBC_ADDR_STATUS && i_wdata[`POBC_ST_ABORT_ERR]) begin
            abort_err <= 1'b0;
        end
    end

    // combined enables follow pins every cycle
    assign next_pll_enable = !live[`POBC_BIT_PLL_OFF] && !i_pll_disable_pin;
    assign next_hiz = !live[`POBC_BIT_DIS_STATE] && !i_disabled_output_state_pin;
    assign next_bank_enable[0] = !live[`POBC_BIT_BANK1_OFF] && !i_bank1_output_disable_pin;
    assign next_bank_enable[1] = !(live[`POBC_BIT_BANK2_OFF] || i_bank2_output_disable_pin);
    assign next_bank_enable[2] = !live[`POBC_BIT_BANK3_OFF] && !i_bank3_output_disable_pin;
    assign next_bank_enable[3] = !live[`POBC_BIT_BANK4_OFF] && !i_bank4_output_disable_pin;
    assign next_bank_enable[4] = !(live[`POBC_BIT_BANK5_OFF] || i_bank5_output_disable_pin);
    assign next_bank_enable[5] = 1'b1;

    assign fbm = live[`POBC_FBM_MSB:`POBC_FBM_LSB];

    // multiplier from code: 1-6, then 8, 10, 12; unused codes give zero
    always @* begin
        case (fbm)
            4'h0: next_factor = 4'h1;
            4'h1: next_factor = 4'h2;
            4'h2: next_factor = 4'h3;
            4'h3: next_factor = 4'h4;
            4'h4: next_factor = 4'h5;
            4'h5: next_factor = 4'h6;
            4'h6: next_factor = 4'h8;
            4'h7: next_factor = 4'hA;
            4'h8: next_factor = 4'hC;
            default: next_factor = 4'h0;
        endcase
    end

    // bank index 0..4 = banks 1..5, index 5 = feedback bank
    genvar g;
    generate
        for (g = 0; g < NBANK; g = g + 1) begin : g_bank
            pobc_skew_decode u_skew (
                .i_code(live[`POBC_SKEW_LSB + 5*(NBANK-1-g) +: 5]),
                .o_skew_steps(dec_steps[4*g +: 4]),
                .o_invert(dec_inv[g]),
                .o_div2(dec_div2[g]),
                .o_div4(dec_div4[g]),
                .o_code_valid(dec_valid[g])
            );

            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_skew_sel[5*g +: 5] <= 5'h00;
                    o_io_std[2*g +: 2] <= 2'h0;
                    o_skew_steps[4*g +: 4] <= 4'h0;
                    o_invert[g] <= 1'b0;
                    o_div2[g] <= 1'b0;
                    o_div4[g] <= 1'b0;
                    o_skew_code_valid[g] <= 1'b0;
                end else begin
                    o_skew_sel[5*g +: 5] <= live[`POBC_SKEW_LSB + 5*(NBANK-1-g) +: 5];
                    o_io_std[2*g +: 2] <= live[`POBC_IOSTD_LSB + 2*(NBANK-1-g) +: 2];
                    o_skew_steps[4*g +: 4] <= dec_steps[4*g +: 4];
                    o_invert[g] <= dec_inv[g];
                    o_div2[g] <= dec_div2[g];
                    o_div4[g] <= dec_div4[g];
                    o_skew_code_valid[g] <= dec_valid[g];
                end
            end
        end
    endgenerate

    // registered pll and bank controls
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pll_enable <= 1'b0;
            o_pll_bypass <= 1'b1;
            o_ref_rising_edge <= 1'b0;
            o_fb_mult_code <= 4'h0;
            o_fb_mult_factor <= 4'h0;
            o_vco_high_range <= 1'b0;
            o_disabled_hiz <= 1'b0;
            o_bank_enable <= {NBANK{1'b0}};
        end else begin
            o_pll_enable <= next_pll_enable;
            o_pll_bypass <= !next_pll_enable;
            o_ref_rising_edge <= live[`POBC_BIT_REF_EDGE];
            o_fb_mult_code <= fbm;
            o_fb_mult_factor <= next_factor;
            o_vco_high_range <= live[`POBC_BIT_VCO_HIGH];
            o_disabled_hiz <= next_hiz;
            o_bank_enable <= next_bank_enable;
        end
    end

    assign status = {11'h000, rx_count, 2'h0, next_bank_enable,
        4'h0, next_hiz, next_pll_enable, abort_err, restored};

    // register read mux, data valid one cycle after the strobe
    always @* begin
        case (i_addr)
            `POBC_ADDR_CFG0: next_rdata = live[31:0];
            `POBC_ADDR_CFG1: next_rdata = live[63:32];
            `POBC_ADDR_CFG2: next_rdata = live[95:64];
            `POBC_ADDR_STAGE0: next_rdata = stage[31:0];
            `POBC_ADDR_STAGE1: next_rdata = stage[63:32];
            `POBC_ADDR_STAGE2: next_rdata = stage[95:64];
            `POBC_ADDR_CTRL: next_rdata = 32'h00000000;
            `POBC_ADDR_STATUS: next_rdata = status;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule // pobc_decode

/* File: pobc_decode_props.sv */
// assertions over the pll and output bank decoder ports
// bound to pobc_decode from the bench top; one clock, async low reset
`timescale 1ns/1ps
module pobc_decode_props #(
    parameter NBANK = 6
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_restore_done,
    input wire i_pll_disable_pin,
    input wire i_disabled_output_state_pin,
    input wire i_bank1_output_disable_pin,
    input wire i_bank2_output_disable_pin,
    input wire i_bank3_output_disable_pin,
    input wire i_bank4_output_disable_pin,
    input wire i_bank5_output_disable_pin,
    input wire o_pll_enable,
    input wire o_pll_bypass,
    input wire [3:0] o_fb_mult_code,
    input wire [3:0] o_fb_mult_factor,
    input wire o_disabled_hiz,
    input wire [NBANK-1:0] o_bank_enable,
    input wire [NBANK*5-1:0] o_skew_sel,
    input wire [NBANK-1:0] o_invert,
    input wire [NBANK-1:0] o_div4
);
    reg restored;
    wire [4:0] pins_off = {i_bank5_output_disable_pin, i_bank4_output_disable_pin,
        i_bank3_output_disable_pin, i_bank2_output_disable_pin, i_bank1_output_disable_pin};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // outputs may leave zero one edge after this is set
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            restored <= 1'b0;
        else if (i_restore_done)
            restored <= 1'b1;
    end
    a_pll_pin_gate: assert property (o_pll_enable |-> !$past(i_pll_disable_pin))
        else $error("pll on with disable pin high");
    a_bypass_inverse: assert property (o_pll_bypass == !o_pll_enable)
        else $error("bypass not inverse of enable");
    a_bank_pin_gate: assert property ((o_bank_enable[4:0] & $past(pins_off)) == 5'h00)
        else $error("bank on with its disable pin high");
    a_feedback_on: assert property ($past(i_rst_n) |-> o_bank_enable[5])
        else $error("feedback bank disabled");
    a_hiz_pin_gate: assert property (o_disabled_hiz |-> !$past(i_disabled_output_state_pin))
        else $error("hi-z state with mode pin high");
    a_mult_four: assert property (o_fb_mult_code == 4'h3 |-> o_fb_mult_factor == 4'h4)
        else $error("multiplier code 3 not four");
    a_invert_code: assert property (o_invert[0] |-> o_skew_sel[4:0] == 5'h10)
        else $error("invert without its code");
    a_div4_code: assert property (o_div4[5] |-> o_skew_sel[29:25] == 5'h12)
        else $error("divide by four without its code");
    a_zero_unrestored: assert property (!restored |-> o_fb_mult_code == 4'h0 && o_skew_sel == '0)
        else $error("config visible before restore");
    c_invert: cover property (o_invert[0]);
    c_div4: cover property (o_div4[5]);
    c_live: cover property (restored && o_pll_enable && !o_bank_enable[1]);
endmodule // pobc_decode_props

/* File: pobc_frame_src.sv */
// model of the serial programming side: sends frames of configuration bytes
// assumes the decoder samples its frame strobes on the rising edge of i_clk
`timescale 1ns/1ps
module pobc_frame_src (
    input wire logic i_clk,
    output logic o_frame_start,
    output logic o_frame_stop,
    output logic o_frame_abort,
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    initial begin
        o_frame_start = 1'b0;
        o_frame_stop = 1'b0;
        o_frame_abort = 1'b0;
        o_byte_valid = 1'b0;
        o_byte = 8'hA5;
    end
    // n bytes msb first, then stop or abort
    task automatic send(input logic [95:0] w, input int n, input logic ab);
        w[95:62] = '0;
        @(posedge i_clk);
        o_frame_start <= 1'b1;
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_frame_start <= 1'b0;
            o_byte_valid <= 1'b1;
            o_byte <= w[95 - 8 * (k % 12) -: 8];
        end
        @(posedge i_clk);
        o_byte_valid <= 1'b0;
        o_byte <= ~o_byte;
        o_frame_abort <= ab;
        o_frame_stop <= !ab;
        @(posedge i_clk);
        o_frame_abort <= 1'b0;
        o_frame_stop <= 1'b0;
    endtask
endmodule // pobc_frame_src

/* File: test_pll_output_bank_config_decode.sv */
// self-checking bench for the pll and output bank decoder
// assumes pobc_decode, pobc_frame_src and pobc_decode_props are compiled first
`timescale 1ns/1ps
`include "pobc_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_pll_output_bank_config_decode;
    logic i_clk, i_rst_n, i_restore_done, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [6:0] pin;
    logic fs, fp, fa, bv;
    logic [7:0] bt;
    logic o_pll_enable, o_pll_bypass, o_ref_rising_edge, o_vco_high_range, o_disabled_hiz;
    logic [3:0] o_fb_mult_code, o_fb_mult_factor;
    logic [5:0] o_bank_enable, o_invert, o_div2, o_div4, o_skew_code_valid;
    logic [29:0] o_skew_sel;
    logic [11:0] o_io_std;
    logic [23:0] o_skew_steps;
    logic [95:0] w, cfg;
    logic [63:0] e;
    int s, mismatches, checks;
    int q_sel[$];
    logic [63:0] q_exp[$];
    event look;
    pobc_frame_src u_pobc_frame_src (.i_clk(i_clk), .o_frame_start(fs), .o_frame_stop(fp),
        .o_frame_abort(fa), .o_byte_valid(bv), .o_byte(bt));
    pobc_decode #(.NBANK(6)) u_pobc_decode (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_frame_start(fs), .i_frame_stop(fp), .i_frame_abort(fa), .i_byte_valid(bv),
        .i_byte(bt), .i_restore_done(i_restore_done), .i_pll_disable_pin(pin[6]),
        .i_disabled_output_state_pin(pin[5]), .i_bank1_output_disable_pin(pin[0]),
        .i_bank2_output_disable_pin(pin[1]), .i_bank3_output_disable_pin(pin[2]),
        .i_bank4_output_disable_pin(pin[3]), .i_bank5_output_disable_pin(pin[4]),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_pll_enable(o_pll_enable), .o_pll_bypass(o_pll_bypass),
        .o_ref_rising_edge(o_ref_rising_edge), .o_fb_mult_code(o_fb_mult_code),
        .o_fb_mult_factor(o_fb_mult_factor), .o_vco_high_range(o_vco_high_range),
        .o_disabled_hiz(o_disabled_hiz), .o_bank_enable(o_bank_enable),
        .o_skew_sel(o_skew_sel), .o_io_std(o_io_std), .o_skew_steps(o_skew_steps),
        .o_invert(o_invert), .o_div2(o_div2), .o_div4(o_div4),
        .o_skew_code_valid(o_skew_code_valid));
    function automatic logic [63:0] obs(input int s);
        if (s == 0)
            obs = {o_pll_enable, o_pll_bypass, o_disabled_hiz, o_ref_rising_edge,
                o_vco_high_range, o_fb_mult_code, o_fb_mult_factor, o_bank_enable};
        else if (s == 1)
            obs = {o_io_std, o_skew_sel};
        else if (s == 4)
            obs = o_rdata;
        else
            obs = {o_skew_code_valid[s-8], o_invert[s-8], o_div2[s-8], o_div4[s-8],
                o_skew_steps[4*(s-8)+:4]};
    endfunction
    function automatic logic [63:0] exp0(input logic [95:0] c);
        logic [5:0] en;
        logic [3:0] f;
        en[5] = 1'b1;
        for (int b = 0; b < 5; b++)
            en[b] = !c[56-b] && !pin[b];
        f = c[51:48];
        f = f < 6 ? f + 4'h1 : f == 6 ? 4'h8 : f == 7 ? 4'hA : f == 8 ? 4'hC : 4'h0;
        exp0 = {!c[57] && !pin[6], c[57] || pin[6], !c[59] && !pin[5], c[58], c[60],
            c[51:48], f, en};
    endfunction
    function automatic logic [63:0] exp1(input logic [95:0] c);
        exp1 = '0;
        for (int g = 0; g < 6; g++) begin
            exp1[5*g+:5] = c[29-5*g-:5];
            exp1[30+2*g+:2] = c[47-2*g-:2];
        end
    endfunction
    function automatic logic [63:0] skw(input logic [4:0] k);
        case (k)
            5'h10: skw = 8'hC0;
            5'h11: skw = 8'hA0;
            5'h12: skw = 8'h90;
            5'h08: skw = 8'h00;
            default: skw = k > 5'h0F ? 8'h00 : {4'h8, k == 0 ? 4'h0 : 4'(8 - k)};
        endcase
    endfunction
    task automatic note(input int s, input logic [63:0] e);
        q_sel.push_back(s);
        q_exp.push_back(e);
        ->look;
    endtask
    task automatic settle;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        note(4, d);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial forever begin
        @(look);
        while (q_sel.size() > 0) begin
            s = q_sel.pop_front();
            e = q_exp.pop_front();
            `CHK(obs(s), e)
        end
    end
    initial begin
        #100us;
        mismatches++;
        end_sim;
    end
    initial begin
        {i_rst_n, i_restore_done, i_wr, i_rd, i_addr, i_wdata, pin} = '0;
        void'($urandom(32'h101C1B1A));
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        w = {$urandom, $urandom, $urandom};
        w[95:62] = '0;
        u_pobc_frame_src.send(w, 12, 1'b0);
        settle;
        note(0, exp0('0));
        note(1, exp1('0));
        @(posedge i_clk);
        i_restore_done <= 1'b1;
        @(posedge i_clk);
        i_restore_done <= 1'b0;
        cfg = w;
        settle;
        note(0, exp0(cfg));
        rd(`POBC_ADDR_CFG0, cfg[31:0]);
        rd(`POBC_ADDR_CFG2, cfg[95:64]);
        rd(8'h40, 32'h0);
        for (int n = 5; n < 14; n += 4) begin
            u_pobc_frame_src.send({$urandom, $urandom, $urandom}, n, n == 5);
            settle;
            note(0, exp0(cfg));
            note(1, exp1(cfg));
        end
        // the thirteen-byte broken frame leaves a count of twelve and the sticky error, which write one clears
        rd(`POBC_ADDR_STATUS, {11'h000, 5'h0C, 2'h0, 1'b1,
            ~{cfg[52], cfg[53], cfg[54], cfg[55], cfg[56]}, 4'h0, !cfg[59], !cfg[57], 2'b11});
        wr(`POBC_ADDR_STATUS, 32'h00000002);
        rd(`POBC_ADDR_STATUS, {11'h000, 5'h0C, 2'h0, 1'b1,
            ~{cfg[52], cfg[53], cfg[54], cfg[55], cfg[56]}, 4'h0, !cfg[59], !cfg[57], 2'b01});
        for (int k = 0; k < 32; k++) begin
            w = {$urandom, $urandom, $urandom};
            w[95:62] = '0;
            w[51:48] = k[3:0];
            w[29:25] = k[4:0];
            w[4:0] = 5'h1F - k[4:0];
            @(posedge i_clk);
            pin <= 7'($urandom);
            u_pobc_frame_src.send(w, 12, 1'b0);
            cfg = w;
            settle;
            note(0, exp0(cfg));
            note(1, exp1(cfg));
            note(8, skw(w[29:25]));
            note(13, skw(w[4:0]));
            @(posedge i_clk);
            pin <= 7'($urandom);
            settle;
            note(0, exp0(cfg));
        end
        w = {$urandom, $urandom, $urandom};
        w[95:62] = '0;
        wr(`POBC_ADDR_STAGE0, w[31:0]);
        wr(`POBC_ADDR_STAGE1, w[63:32]);
        wr(`POBC_ADDR_STAGE2, w[95:64]);
        rd(`POBC_ADDR_STAGE1, w[63:32]);
        wr(`POBC_ADDR_CTRL, 32'h1);
        cfg = w;
        settle;
        note(1, exp1(cfg));
        wr(8'h40, 32'hFFFFFFFF);
        settle;
        note(0, exp0(cfg));
        rd(`POBC_ADDR_CFG1, cfg[63:32]);
        settle;
        end_sim;
    end
endmodule // test_pll_output_bank_config_decode
bind pobc_decode pobc_decode_props #(.NBANK(NBANK)) u_pobc_decode_props (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_restore_done(i_restore_done), .i_pll_disable_pin(i_pll_disable_pin),
    .i_disabled_output_state_pin(i_disabled_output_state_pin),
    .i_bank1_output_disable_pin(i_bank1_output_disable_pin),
    .i_bank2_output_disable_pin(i_bank2_output_disable_pin),
    .i_bank3_output_disable_pin(i_bank3_output_disable_pin),
    .i_bank4_output_disable_pin(i_bank4_output_disable_pin),
    .i_bank5_output_disable_pin(i_bank5_output_disable_pin), .o_pll_enable(o_pll_enable),
    .o_pll_bypass(o_pll_bypass), .o_fb_mult_code(o_fb_mult_code),
    .o_fb_mult_factor(o_fb_mult_factor), .o_disabled_hiz(o_disabled_hiz),
    .o_bank_enable(o_bank_enable), .o_skew_sel(o_skew_sel), .o_invert(o_invert),
    .o_div4(o_div4));
